// [shared/plnci_pkg.sv]
// constants and types shared by the local node register block
// Operation
// RQ1 - node registers take byte or word transfers only; only size 2 is refused, size 3 is accepted
// RQ2 - decode 32-byte window: local, remote, dma
// RQ3 - command bit 7 clears error status flags
// RQ4 - command bit 6 clears inbound interrupt
// RQ5 - command bit 5 drives outbound interrupt request
// RQ6 - control bit 7 shows interrupt is active
// RQ7 - control bit 6 gates normal interrupt sources
// RQ8 - control bit 5 gates error interrupt sources
// RQ9 - select field routes outbound interrupt to line
// RQ10 - software keeps one source per cable line
// RQ11 - status bit 7 latches link data error
// RQ12 - status bit 6 latches remote bus error
// RQ13 - status bit 5 latches inbound interrupt
// RQ14 - 30 us no answer: abort, set bit 2
// RQ15 - software flushes link after timeout by read
// RQ16 - status bit 0 follows remote power/cable state
// RQ17 - power/cable state raises no error interrupt
// RQ18 - pending register shows seven cable lines
// RQ19 - interrupt is level of enabled pending sources
package plnci_pkg;

	// window layout
	localparam int unsigned WIN_ADDR_W   = 5;
	localparam logic [4:0]  WIN_LOCAL    = 5'h00;
	localparam logic [4:0]  WIN_REMOTE   = 5'h08;
	localparam logic [4:0]  WIN_DMA      = 5'h10;

	// local register offsets
	localparam logic [2:0]  OFS_LOCAL_COMMAND     = 3'h0;
	localparam logic [2:0]  OFS_INTERRUPT_CONTROL = 3'h1;
	localparam logic [2:0]  OFS_LOCAL_STATUS      = 3'h2;
	localparam logic [2:0]  OFS_CABLE_PENDING     = 3'h3;
	localparam logic [2:0]  OFS_HOST_BUS_CONTROL  = 3'h4;

	// local command fields
	localparam int unsigned CMD_CLEAR_STATUS  = 7;
	localparam int unsigned CMD_CLEAR_INBOUND = 6;
	localparam int unsigned CMD_SEND_OUTBOUND = 5;

	// interrupt control fields
	localparam int unsigned ICR_ACTIVE        = 7;
	localparam int unsigned ICR_NORMAL_EN     = 6;
	localparam int unsigned ICR_ERROR_EN      = 5;
	localparam int unsigned ICR_SEL_MSB       = 2;

	// local status fields
	localparam int unsigned STA_LINK_ERR      = 7;
	localparam int unsigned STA_REMOTE_BERR   = 6;
	localparam int unsigned STA_INBOUND       = 5;
	localparam int unsigned STA_TIMEOUT       = 2;
	localparam int unsigned STA_REMOTE_OFF    = 0;

	// host bus control keeps its three low bits
	localparam logic [7:0]  HBC_MASK          = 8'h07;

	// reset values
	localparam logic [7:0]  RST_LOCAL_COMMAND = 8'h00;
	localparam logic [7:0]  RST_INT_CONTROL   = 8'h00;
	localparam logic [7:0]  RST_HOST_BUS_CTRL = 8'h00;

	// timing
	localparam int unsigned CLK_MHZ           = 10;
	localparam int unsigned TIMEOUT_US        = 30;
	localparam int unsigned TIMEOUT_CYCLES    = TIMEOUT_US * CLK_MHZ;
	localparam int unsigned TMO_W             = 9;

	// window region of an access
	typedef enum logic [1:0] {
		PLNCI_REG_LOCAL  = 2'b00,
		PLNCI_REG_REMOTE = 2'b01,
		PLNCI_REG_DMA    = 2'b10
	} plnci_region_type;

	// remote access watchdog states
	typedef enum logic [1:0] {
		PLNCI_IDLE = 2'b00,
		PLNCI_WAIT = 2'b01,
		PLNCI_DONE = 2'b10
	} plnci_wd_type;

endpackage : plnci_pkg

// [hdl/plnci_timeout.sv]
// remote command watchdog: times out an unanswered remote access
module plnci_timeout
	import plnci_pkg::*;
(
	input  wire logic clk_sys,     // system clock
	input  wire logic sys_rst,     // async reset, high
	input  wire logic start,       // remote command issued
	input  wire logic answer,      // remote answered
	output logic      busy,        // waiting for answer
	output logic      expired      // one-cycle timeout pulse
);

	plnci_wd_type           state;      // watchdog state
	logic [TMO_W-1:0]       count;      // cycles waited

	// wait for the answer, give up after the limit
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			state   <= PLNCI_IDLE;
			count   <= '0;
			expired <= 1'b0;
		end else begin
			expired <= 1'b0;
			case (state)
				PLNCI_IDLE: begin
					count <= '0;
					if (start) begin
						state <= PLNCI_WAIT;
					end
				end
				PLNCI_WAIT: begin
					if (answer) begin
						state <= PLNCI_IDLE;  // answered in time
					end else if (count == TMO_W'(TIMEOUT_CYCLES - 1)) begin
						state   <= PLNCI_DONE;  // RQ14
						expired <= 1'b1;        // RQ14
					end else begin
						count <= count + TMO_W'(1);
					end
				end
				PLNCI_DONE: begin
					count <= '0;
					if (start) begin
						state <= PLNCI_WAIT;  // command in abort cycle is watched
					end else begin
						state <= PLNCI_IDLE;  // operation terminated
					end
				end
				default: begin
					state <= PLNCI_IDLE;
				end
			endcase
		end
	end

	// busy while a command is outstanding
	assign busy = (state == PLNCI_WAIT);

endmodule : plnci_timeout

// [hdl/plnci_route.sv]
// outbound interrupt router onto the seven cable lines
module plnci_route
	import plnci_pkg::*;
(
	input  wire logic       clk_sys,   // system clock
	input  wire logic       sys_rst,   // async reset, high
	input  wire logic       request,   // outbound request level
	input  wire logic [2:0] select,    // line choice, zero is off
	output logic      [7:1] lines      // cable lines, registered
);

	genvar g;

	// one flop per line, driven when selected
	generate
		for (g = 1; g <= 7; g++) begin : gen_line
			always_ff @(posedge clk_sys or posedge sys_rst) begin
				if (sys_rst) begin
					lines[g] <= 1'b0;
				end else begin
					lines[g] <= request && (select == 3'(g));  // RQ9
				end
			end
		end
	endgenerate

endmodule : plnci_route

// [hdl/plnci_node.sv]
// local node register block with interrupt merge
module plnci_node
	import plnci_pkg::*;
(
	input  wire logic       clk_sys,          // system clock
	input  wire logic       sys_rst,          // async reset, high
	// node window access
	input  wire logic       acc_valid,        // access strobe, one cycle
	input  wire logic       acc_write,        // 1 write, 0 read
	input  wire logic [4:0] acc_addr,         // byte address in window
	input  wire logic [1:0] acc_size,         // 0 byte,1 word,2 long
	input  wire logic [15:0] acc_wdata,       // write data
	output logic      [15:0] acc_rdata,       // read data, registered
	output logic            acc_done,         // local access answered
	output logic            acc_refused,      // long access refused
	output logic            remote_sel,       // remote region strobe
	output logic            dma_sel,          // dma region strobe
	// link events from the fiber side
	input  wire logic       link_data_err,    // link data error pulse
	input  wire logic       remote_berr,      // remote bus error pulse
	input  wire logic       inbound_irq,      // inbound interrupt pulse
	input  wire logic       remote_off,       // remote power/cable off
	input  wire logic       remote_answer,    // remote command answered
	input  wire logic [7:1] cable_pending_in, // cable lines pending
	input  wire logic       dma_done,         // dma done level
	input  wire logic       dma_check_err,    // dma block check level
	input  wire logic       parity_err,       // parity error level
	// outputs
	output logic      [7:1] cable_lines_out,  // outbound cable lines
	output logic            remote_abort,     // timeout terminate pulse
	output logic            host_irq,         // host interrupt level
	output logic      [2:0] host_bus_ctrl     // swap, preempt, abort
);

	// registers and internal signals
	logic [7:0] local_command;     // stored command bits
	logic [7:0] interrupt_control; // stored control bits
	logic [7:0] host_bus_control;  // host bus options
	logic       link_err_flag;     // status bit 7
	logic       berr_flag;         // status bit 6
	logic       inbound_flag;      // status bit 5
	logic       timeout_flag;      // status bit 2
	logic [7:0] local_status;      // assembled status
	logic [7:0] icr_view;          // control as read
	logic       normal_pending;    // any normal source
	logic       error_pending;     // any error source
	logic       irq_level;         // merged interrupt
	logic       tmo_busy;          // watchdog busy
	logic       tmo_expired;       // watchdog fired
	plnci_region_type region;      // decoded region

	// region decode of the window
	function automatic plnci_region_type region_of(input logic [4:0] a);
		if (a[4]) begin
			region_of = PLNCI_REG_DMA;
		end else if (a[3]) begin
			region_of = PLNCI_REG_REMOTE;
		end else begin
			region_of = PLNCI_REG_LOCAL;
		end
	endfunction : region_of

	// write strobe for a local register at an offset
	function automatic logic local_wr(input logic [4:0] a,
	                                  input logic [2:0] ofs);
		local_wr = (region_of(a) == PLNCI_REG_LOCAL) && (a[2:0] == ofs);
	endfunction : local_wr

	logic acc_ok;     // accepted access
	logic wr_ok;      // accepted write
	logic clr_status; // clear error flags
	logic clr_inbound;// clear inbound flag

	// long accesses are refused outright
	assign acc_ok      = acc_valid && (acc_size != 2'd2);  // RQ1
	assign acc_refused = acc_valid && (acc_size == 2'd2);  // RQ1
	assign wr_ok       = acc_ok && acc_write;
	assign region      = region_of(acc_addr);              // RQ2
	assign remote_sel  = acc_ok && (region == PLNCI_REG_REMOTE); // RQ2
	assign dma_sel     = acc_ok && (region == PLNCI_REG_DMA);    // RQ2

	// write-only command pulses
	assign clr_status  = wr_ok && local_wr(acc_addr, OFS_LOCAL_COMMAND)
	                     && acc_wdata[CMD_CLEAR_STATUS];  // RQ3
	assign clr_inbound = wr_ok && local_wr(acc_addr, OFS_LOCAL_COMMAND)
	                     && acc_wdata[CMD_CLEAR_INBOUND]; // RQ4

	// local command keeps only the send bit
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			local_command <= RST_LOCAL_COMMAND;
		end else if (wr_ok && local_wr(acc_addr, OFS_LOCAL_COMMAND)) begin
			local_command <= RST_LOCAL_COMMAND;
			local_command[CMD_SEND_OUTBOUND] <=
				acc_wdata[CMD_SEND_OUTBOUND];  // RQ5
		end
	end

	// interrupt control: enables and line select
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			interrupt_control <= RST_INT_CONTROL;
		end else if (wr_ok &&
		             local_wr(acc_addr, OFS_INTERRUPT_CONTROL)) begin
			interrupt_control <= 8'h00;
			interrupt_control[ICR_NORMAL_EN] <= acc_wdata[ICR_NORMAL_EN];
			interrupt_control[ICR_ERROR_EN]  <= acc_wdata[ICR_ERROR_EN];
			interrupt_control[ICR_SEL_MSB:0] <=
				acc_wdata[ICR_SEL_MSB:0];  // RQ9
		end
	end

	// host bus control, low three bits stored
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			host_bus_control <= RST_HOST_BUS_CTRL;
		end else if (wr_ok &&
		             local_wr(acc_addr, OFS_HOST_BUS_CONTROL)) begin
			host_bus_control <= acc_wdata[7:0] & HBC_MASK;
		end
	end
	assign host_bus_ctrl = host_bus_control[2:0];

	// sticky error flags, a new event beats the clear
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			link_err_flag <= 1'b0;
			berr_flag     <= 1'b0;
			timeout_flag  <= 1'b0;
		end else begin
			if (link_data_err) begin
				link_err_flag <= 1'b1;           // RQ11
			end else if (clr_status) begin
				link_err_flag <= 1'b0;           // RQ3
			end
			if (remote_berr) begin
				berr_flag <= 1'b1;               // RQ12
			end else if (clr_status) begin
				berr_flag <= 1'b0;               // RQ3
			end
			if (tmo_expired) begin
				timeout_flag <= 1'b1;            // RQ14
			end else if (clr_status) begin
				timeout_flag <= 1'b0;            // RQ3
			end
		end
	end

	// inbound interrupt flag
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			inbound_flag <= 1'b0;
		end else if (inbound_irq) begin
			inbound_flag <= 1'b1;                // RQ13
		end else if (clr_inbound) begin
			inbound_flag <= 1'b0;                // RQ4
		end
	end

	// status view, bit 0 follows the live condition
	always_comb begin
		local_status                  = 8'h00;
		local_status[STA_LINK_ERR]    = link_err_flag;
		local_status[STA_REMOTE_BERR] = berr_flag;
		local_status[STA_INBOUND]     = inbound_flag;
		local_status[STA_TIMEOUT]     = timeout_flag;
		local_status[STA_REMOTE_OFF]  = remote_off;  // RQ16
	end

	// source grouping; remote_off is left out on purpose
	assign normal_pending = inbound_flag |
	                        local_command[CMD_SEND_OUTBOUND] |
	                        (|cable_pending_in) | dma_done;    // RQ7
	assign error_pending  = link_err_flag | berr_flag | timeout_flag |
	                        parity_err | dma_check_err;        // RQ8 RQ17
	assign irq_level = (normal_pending &
	                    interrupt_control[ICR_NORMAL_EN]) |
	                   (error_pending &
	                    interrupt_control[ICR_ERROR_EN]);      // RQ19

	// registered interrupt output
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			host_irq <= 1'b0;
		end else begin
			host_irq <= irq_level;  // RQ19
		end
	end

	// control as read, bit 7 shows the interrupt
	always_comb begin
		icr_view             = interrupt_control;
		icr_view[ICR_ACTIVE] = host_irq;  // RQ6
	end

	// read data and answer
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			acc_rdata <= 16'h0000;
			acc_done  <= 1'b0;
		end else begin
			acc_done <= acc_ok && (region == PLNCI_REG_LOCAL);
			if (acc_ok && !acc_write && (region == PLNCI_REG_LOCAL)) begin
				case (acc_addr[2:0])
					OFS_LOCAL_COMMAND: begin
						acc_rdata <= {8'h00, local_command};
					end
					OFS_INTERRUPT_CONTROL: begin
						acc_rdata <= {8'h00, icr_view};  // RQ6
					end
					OFS_LOCAL_STATUS: begin
						acc_rdata <= {8'h00, local_status};
					end
					OFS_CABLE_PENDING: begin
						acc_rdata <= {8'h00, cable_pending_in, 1'b0}; // RQ18
					end
					OFS_HOST_BUS_CONTROL: begin
						acc_rdata <= {8'h00, host_bus_control};
					end
					default: begin
						acc_rdata <= 16'h0000;  // reserved reads zero
					end
				endcase
			end
		end
	end

	// watchdog on remote region accesses
	plnci_timeout u_timeout (
		.clk_sys (clk_sys),
		.sys_rst (sys_rst),
		.start   (remote_sel && !tmo_busy),
		.answer  (remote_answer),
		.busy    (tmo_busy),
		.expired (tmo_expired)
	);
	assign remote_abort = tmo_expired;  // RQ14

	// outbound interrupt onto the chosen line
	plnci_route u_route (
		.clk_sys (clk_sys),
		.sys_rst (sys_rst),
		.request (local_command[CMD_SEND_OUTBOUND]),  // RQ5
		.select  (interrupt_control[ICR_SEL_MSB:0]),
		.lines   (cable_lines_out)
	);

endmodule : plnci_node

// [dv/plnci_node_sva.sv]
// port assertions for the local node register block
module plnci_node_sva (
	input  wire logic        clk_sys,         // clock
	input  wire logic        sys_rst,         // reset
	input  wire logic        acc_valid,       // access strobe
	input  wire logic        acc_write,       // write flag
	input  wire logic [4:0]  acc_addr,        // window address
	input  wire logic [1:0]  acc_size,        // transfer size
	input  wire logic [15:0] acc_wdata,       // write data
	input  wire logic        acc_done,        // local answer
	input  wire logic        acc_refused,     // long refused
	input  wire logic        remote_sel,      // remote strobe
	input  wire logic        dma_sel,         // dma strobe
	input  wire logic        remote_answer,   // remote answered
	input  wire logic [7:1]  cable_lines_out, // outbound lines
	input  wire logic        remote_abort,    // timeout pulse
	input  wire logic [2:0]  host_bus_ctrl    // bus control
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	logic       ok;       // accepted access
	logic [9:0] wait_cnt; // cycles of an unanswered remote wait
	assign ok = acc_valid && acc_size != 2'h2;
	// count the remote wait, cleared by answer or abort
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst)
			wait_cnt <= 10'h000;
		else if (ok && acc_addr[4:3] == 2'h1 &&
		         (wait_cnt == 10'h000 || remote_abort))
			wait_cnt <= 10'h001;
		else if (remote_answer || remote_abort)
			wait_cnt <= 10'h000;
		else if (wait_cnt != 10'h000)
			wait_cnt <= wait_cnt + 10'h001;
	end
	a_long_refused: assert property (acc_valid && acc_size == 2'h2 |->
		acc_refused && !remote_sel && !dma_sel ##1 !acc_done)
		else $error("long access not refused");
	a_local_done: assert property (ok && acc_addr < 5'h08 |=> acc_done)
		else $error("local access not answered");
	a_done_cause: assert property (acc_done |->
		$past(ok) && $past(acc_addr) < 5'h08)
		else $error("answer without local access");
	a_region_sel: assert property (ok |-> remote_sel ==
		(acc_addr[4:3] == 2'h1) && dma_sel == acc_addr[4])
		else $error("window region decode wrong");
	a_line_single: assert property ($onehot0(cable_lines_out))
		else $error("more than one cable line driven");
	a_hbc_write: assert property (ok && acc_write && acc_addr == 5'h04
		|=> host_bus_ctrl == $past(acc_wdata[2:0]))
		else $error("bus control not written");
	a_abort_time: assert property (remote_abort |->
		wait_cnt inside {10'd300, 10'd301})
		else $error("timeout at wrong moment");
	a_abort_late: assert property (wait_cnt <= 10'd301)
		else $error("timeout missed");
	a_abort_pulse: assert property (remote_abort |=> !remote_abort)
		else $error("abort longer than one cycle");
endmodule : plnci_node_sva
bind plnci_node plnci_node_sva u_sva (.clk_sys(clk_sys), .sys_rst(sys_rst),
	.acc_valid(acc_valid), .acc_write(acc_write), .acc_addr(acc_addr),
	.acc_size(acc_size), .acc_wdata(acc_wdata), .acc_done(acc_done),
	.acc_refused(acc_refused), .remote_sel(remote_sel), .dma_sel(dma_sel),
	.remote_answer(remote_answer), .cable_lines_out(cable_lines_out),
	.remote_abort(remote_abort), .host_bus_ctrl(host_bus_ctrl));

// [dv/plnci_remote.sv]
// remote adapter stand-in answering remote node commands
module plnci_remote (
	input  wire logic       clk_sys,       // clock
	input  wire logic       sys_rst,       // reset
	input  wire logic       remote_sel,    // command issued
	input  wire logic [8:0] ans_dly,       // answer delay, zero never
	output logic            remote_answer  // answer pulse
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [8:0] cnt; // cycles left before answering
	// answer after the chosen delay, or stay silent
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			cnt <= 9'h000;
			remote_answer <= 1'b0;
		end else begin
			remote_answer <= cnt == 9'h001;
			if (remote_sel && cnt == 9'h000)
				cnt <= ans_dly;
			else if (cnt != 9'h000)
				cnt <= cnt - 9'h001;
		end
	end
endmodule : plnci_remote

// [dv/plnci_node_tb.sv]
// self-checking bench for the local node register block
module plnci_node_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk_sys = 1'b0;   // clock
	logic        sys_rst = 1'b1;   // reset
	logic        acc_valid = 1'b0; // access strobe
	logic        acc_write = 1'b0; // write flag
	logic [4:0]  acc_addr = 5'h00; // window address
	logic [1:0]  acc_size = 2'h0;  // transfer size
	logic [15:0] acc_wdata = 16'h0000, acc_rdata, q_rd;
	logic        acc_done, acc_refused, remote_sel, dma_sel;
	logic        link_data_err = 1'b0, remote_berr = 1'b0;
	logic        inbound_irq = 1'b0, remote_off = 1'b0, remote_answer;
	logic        dma_done = 1'b0, dma_check_err = 1'b0, parity_err = 1'b0;
	logic [7:1]  cable_pending_in = 7'h00, cable_lines_out;
	logic        remote_abort, host_irq, aborted;
	logic [2:0]  host_bus_ctrl;
	logic [8:0]  ans_dly = 9'h002; // far side answer delay
	logic [4:0]  win [4] = '{5'h08, 5'h0f, 5'h10, 5'h1f};
	int          n_errors = 0;
	int          n_checks = 0;
	plnci_node u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.acc_valid(acc_valid), .acc_write(acc_write), .acc_addr(acc_addr),
		.acc_size(acc_size), .acc_wdata(acc_wdata), .acc_rdata(acc_rdata),
		.acc_done(acc_done), .acc_refused(acc_refused),
		.remote_sel(remote_sel), .dma_sel(dma_sel),
		.link_data_err(link_data_err), .remote_berr(remote_berr),
		.inbound_irq(inbound_irq), .remote_off(remote_off),
		.remote_answer(remote_answer), .cable_pending_in(cable_pending_in),
		.dma_done(dma_done), .dma_check_err(dma_check_err),
		.parity_err(parity_err), .cable_lines_out(cable_lines_out),
		.remote_abort(remote_abort), .host_irq(host_irq),
		.host_bus_ctrl(host_bus_ctrl));
	plnci_remote u_far (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.remote_sel(remote_sel), .ans_dly(ans_dly),
		.remote_answer(remote_answer));
	// clock source
	initial begin
		forever #50 clk_sys = ~clk_sys;
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic results();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : results
	// one window access, entered and left at a falling edge
	task automatic acc(input logic w, input logic [4:0] a,
			input logic [7:0] d, input logic [1:0] s);
		logic ok;
		logic [2:0] es;
		ok = s != 2'h2;
		es = {!ok, ok && a[4:3] == 2'h1, ok && a[4]};
		acc_write = w;
		acc_addr = a;
		acc_wdata = {8'h00, d};
		acc_size = s;
		acc_valid = 1'b1;
		#1;
		check(16'({acc_refused, remote_sel, dma_sel}), 16'(es));
		@(negedge clk_sys);
		acc_valid = 1'b0;
		check(16'(acc_done), 16'(ok && a < 5'h08));
		q_rd = acc_rdata;
		@(negedge clk_sys);
	endtask : acc
	task automatic rd(input logic [4:0] a, input logic [7:0] e);
		acc(1'b0, a, 8'h00, 2'h0);
		check(q_rd, 16'(e));
	endtask : rd
	// one-cycle pulse on the three link events
	task automatic events(input logic [2:0] ev);
		{link_data_err, remote_berr, inbound_irq} = ev;
		@(negedge clk_sys);
		{link_data_err, remote_berr, inbound_irq} = 3'h0;
		repeat (2) @(negedge clk_sys);
	endtask : events
	// watchdog against a hang
	initial begin
		repeat (5000) @(posedge clk_sys);
		n_errors++;
		results();
	end
	// main test sequence
	initial begin
		repeat (16) @(negedge clk_sys);
		sys_rst = 1'b0;
		@(negedge clk_sys);
		rd(5'h00, 8'h00);
		rd(5'h01, 8'h00);
		rd(5'h04, 8'h00);
		rd(5'h02, 8'h00);
		acc(1'b1, 5'h04, 8'hff, 2'h1);
		check(16'(host_bus_ctrl), 16'h0007);
		acc(1'b1, 5'h04, 8'h00, 2'h2);
		rd(5'h04, 8'h07);
		$display("test registers done");
		// regions: byte and long at each edge of remote and dma space
		for (int i = 0; i < 8; i++) begin
			acc(1'b0, win[i[1:0]], 8'h00, {i[2], 1'b0});
			repeat (3) @(negedge clk_sys);
		end
		$display("test window done");
		wr_loop();
		events(3'h7);
		rd(5'h02, 8'he0);
		acc(1'b1, 5'h00, 8'h80, 2'h0);
		rd(5'h02, 8'h20);
		acc(1'b1, 5'h00, 8'h40, 2'h0);
		rd(5'h02, 8'h00);
		$display("test status done");
		acc(1'b1, 5'h01, 8'h20, 2'h0);
		remote_off = 1'b1;
		events(3'h1);
		rd(5'h02, 8'h21);
		check(16'(host_irq), 16'h0000);
		remote_off = 1'b0;
		rd(5'h02, 8'h20);
		events(3'h4);
		check(16'(host_irq), 16'h0001);
		rd(5'h01, 8'ha0);
		acc(1'b1, 5'h01, 8'h40, 2'h0);
		check(16'(host_irq), 16'h0001);
		acc(1'b1, 5'h00, 8'hc0, 2'h0);
		check(16'(host_irq), 16'h0000);
		rd(5'h01, 8'h40);
		cable_pending_in = 7'h41;
		rd(5'h03, 8'h82);
		check(16'(host_irq), 16'h0001);
		cable_pending_in = 7'h00;
		// dma done alone, then gated off by the normal enable
		dma_done = 1'b1;
		repeat (2) @(negedge clk_sys);
		check(16'(host_irq), 16'h0001);
		acc(1'b1, 5'h01, 8'h20, 2'h0);
		check(16'(host_irq), 16'h0000);
		// parity and block check levels as error sources
		dma_done = 1'b0;
		parity_err = 1'b1;
		repeat (2) @(negedge clk_sys);
		check(16'(host_irq), 16'h0001);
		{parity_err, dma_check_err} = 2'b01;
		repeat (2) @(negedge clk_sys);
		check(16'(host_irq), 16'h0001);
		acc(1'b1, 5'h01, 8'h00, 2'h0);
		check(16'(host_irq), 16'h0000);
		dma_check_err = 1'b0;
		$display("test interrupt done");
		ans_dly = 9'h000;
		aborted = 1'b0;
		acc(1'b0, 5'h08, 8'h00, 2'h0);
		repeat (320) begin
			@(negedge clk_sys);
			aborted = aborted | remote_abort;
		end
		check(16'(aborted), 16'h0001);
		rd(5'h02, 8'h04);
		acc(1'b1, 5'h00, 8'h80, 2'h0);
		ans_dly = 9'h0fa;
		acc(1'b0, 5'h08, 8'h00, 2'h0); // flush read, data ignored
		repeat (320) @(negedge clk_sys);
		rd(5'h02, 8'h00);
		$display("test timeout done");
		results();
	end
	// route the outbound request over every select value
	task automatic wr_loop();
		acc(1'b1, 5'h00, 8'h20, 2'h0);
		rd(5'h00, 8'h20);
		for (int i = 0; i < 8; i++) begin
			acc(1'b1, 5'h01, i[7:0], 2'h0); // one source per line
			check(16'(cable_lines_out), (i == 0) ? 16'h0 : 16'(1 << (i - 1)));
		end
		acc(1'b1, 5'h00, 8'h00, 2'h0);
		check(16'(cable_lines_out), 16'h0000);
		$display("test outbound done");
	endtask : wr_loop
endmodule : plnci_node_tb
